/* rtl/clk_divider.v */
// Programmable divider producing a one-cycle enable pulse
`timescale 1ns/1ns
module clk_divider #(
	parameter WIDTH = 16
) (
	// Clock and reset
	input  wire             clk,
	input  wire             nrst,
	// Control
	input  wire             run,
	input  wire [WIDTH-1:0] divisor,
	// Enable pulse
	output reg              tick
);
	reg [WIDTH-1:0] cnt_q;

	// Count down from divisor; restart counting whenever idle
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_q <= {WIDTH{1'b0}};
			tick  <= 1'b0;
		end else if (!run) begin
			cnt_q <= {WIDTH{1'b0}};
			tick  <= 1'b0;
		end else if (cnt_q == {WIDTH{1'b0}}) begin
			cnt_q <= divisor;
			tick  <= 1'b1;
		end else begin
			cnt_q <= cnt_q - {{(WIDTH-1){1'b0}}, 1'b1};
			tick  <= 1'b0;
		end
	end
endmodule // clk_divider

/* rtl/rx_signal_strength_monitor.v */
// Receive-side strength monitor: mode, IF gain, filters, strength estimator, alarm, data paths
//
// Operation
// - Writing mode code 011 puts the device into receive operation.
// - IF gain selectable -13.5 dB to 0 dB in 4.5 dB steps, reset 0 dB.
// - One enable bit selects complex polyphase or plain low-pass channel filter.
// - Strength sampled 16 times per second IF or deviation period.
// - Average of latest 16 samples, refreshed once per sample.
// - One LSB of strength value equals 0.5 dB.
// - Alarm flag sets when strength rises above programmed alarm level.
// - Alarm flag stays set until host writes one to clear it.
// - Route bits steer receive interrupt onto event pin 0 or pin 1.
// - FSK demodulator bit from I/Q phase; feeds bit sync or raw output.
// - Bit sync gives clock and data continuous, or clean bits when buffered.
//
// The implementer's own choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`include "rx_strength_regs.vh"
module rx_signal_strength_monitor #(
	parameter DEV_W   = 8,
	parameter LEVEL_W = 8
) (
	// Clock and reset
	input  wire               clk,
	input  wire               nrst,
	// Wishbone slave
	input  wire               wb_cyc_i,
	input  wire               wb_stb_i,
	input  wire               wb_we_i,
	input  wire [3:0]         wb_adr_i,
	input  wire [3:0]         wb_sel_i,
	input  wire [31:0]        wb_dat_i,
	output reg  [31:0]        wb_dat_o,
	output wire               wb_ack_o,
	// Baseband from the analog front end (asynchronous)
	input  wire               basebandI,
	input  wire               basebandQ,
	input  wire [LEVEL_W-1:0] rawLevel,
	// Analog controls
	output wire               receiveActive,
	output wire [1:0]         ifGainSelect,
	output wire               complexFilterEnable,
	output wire [3:0]         passiveFilterBandwidth,
	output wire [3:0]         lowpassCutoffSelect,
	output wire [3:0]         complexFilterCenter,
	// Data to host
	output reg                dataOut,
	output reg                dataClk,
	output reg                fifoBitValid,
	output reg                fifoBit,
	// Event pins and interrupt
	output wire               event_pin_0,
	output wire               event_pin_1,
	output wire               irq
);
	// ****************************************
	// Input synchronisers
	// ****************************************
	reg  [1:0]         iSync_q;
	reg  [1:0]         qSync_q;
	reg  [LEVEL_W-1:0] lvlMeta_q;
	reg  [LEVEL_W-1:0] lvlSync_q;
	reg  [LEVEL_W-1:0] lvlPrev_q;
	reg  [LEVEL_W-1:0] lvlStable_q;

	// Two stages before any logic sees the front-end signals
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			iSync_q   <= 2'h0;
			qSync_q   <= 2'h0;
			lvlMeta_q <= {LEVEL_W{1'b0}};
			lvlSync_q <= {LEVEL_W{1'b0}};
		end else begin
			iSync_q   <= {iSync_q[0], basebandI};
			qSync_q   <= {qSync_q[0], basebandQ};
			lvlMeta_q <= rawLevel;
			lvlSync_q <= lvlMeta_q;
		end
	end

	// A multi-bit level word may be caught mid-change by the synchroniser.
	// Only a value seen unchanged on two consecutive cycles is passed on;
	// this costs two cycles of latency, far below the sample spacing.
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			lvlPrev_q   <= {LEVEL_W{1'b0}};
			lvlStable_q <= {LEVEL_W{1'b0}};
		end else begin
			lvlPrev_q <= lvlSync_q;
			if (lvlSync_q == lvlPrev_q) begin
				lvlStable_q <= lvlSync_q;
			end
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	// Map, byte addressed, one 32-bit word per offset:
	//   MODE     [2:0] operating mode, [5:4] IF gain code,
	//            [15:8] deviation setting, [31:16] bit-rate divider
	//   RXCFG    [0] complex filter enable, [1] route to pin 0,
	//            [2] route to pin 1, [3] bit sync enable, [4] buffered,
	//            [11:8] passive bandwidth, [15:12] cutoff, [19:16] center
	//   ALARM    [7:0] alarm level in 0.5 dB steps, [8] interrupt mask
	//   STRENGTH [7:0] averaged strength, read only,
	//            [16] alarm flag, write one to clear
	// Unmapped offsets read zero and ignore writes, so software probing
	// for fields that this block lacks sees a harmless zero.
	reg  [2:0]         mode_q;
	reg  [1:0]         ifGain_q;
	reg  [DEV_W-1:0]   deviation_q;
	reg  [4:0]         rxCtrl_q;
	reg  [3:0]         passive_q;
	reg  [3:0]         cutoff_q;
	reg  [3:0]         center_q;
	reg  [LEVEL_W-1:0] alarmLevel_q;
	reg  [15:0]        bitDiv_q;
	reg                alarmFlag_q;
	reg                alarmMask_q;
	reg                ack_q;
	wire [LEVEL_W-1:0] strength;
	wire               strengthValid;

	wire wbReq   = wb_cyc_i & wb_stb_i & ~ack_q;
	wire wbWrite = wbReq & wb_we_i;
	wire wbRead  = wbReq & ~wb_we_i;
	assign wb_ack_o = ack_q;

	// One wait-free ack per request, dropped the cycle after
	always @(posedge clk or negedge nrst) begin
		if (!nrst) ack_q <= 1'b0;
		else       ack_q <= wbReq;
	end

	// Configuration writes, per byte lane
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			mode_q       <= `MODE_RESET;
			ifGain_q     <= `IFGAIN_RESET;
			deviation_q  <= `DEV_RESET;
			rxCtrl_q     <= 5'h0;
			passive_q    <= 4'h0;
			cutoff_q     <= 4'h0;
			center_q     <= 4'h0;
			alarmLevel_q <= {LEVEL_W{1'b0}};
			bitDiv_q     <= `BITRATE_DIV_RST;
			alarmMask_q  <= 1'b0;
		end else if (wbWrite) begin
			case (wb_adr_i)
				`REG_MODE: begin
					if (wb_sel_i[0]) mode_q      <= wb_dat_i[2:0];
					if (wb_sel_i[0]) ifGain_q    <= wb_dat_i[5:4];
					if (wb_sel_i[1]) deviation_q <= wb_dat_i[15:8];
					if (wb_sel_i[2]) bitDiv_q[7:0]  <= wb_dat_i[23:16];
					if (wb_sel_i[3]) bitDiv_q[15:8] <= wb_dat_i[31:24];
				end
				`REG_RXCFG: begin
					if (wb_sel_i[0]) rxCtrl_q  <= wb_dat_i[4:0];
					if (wb_sel_i[1]) passive_q <= wb_dat_i[11:8];
					if (wb_sel_i[1]) cutoff_q  <= wb_dat_i[15:12];
					if (wb_sel_i[2]) center_q  <= wb_dat_i[19:16];
				end
				`REG_ALARM: begin
					if (wb_sel_i[0]) alarmLevel_q <= wb_dat_i[LEVEL_W-1:0];
					if (wb_sel_i[1]) alarmMask_q  <= wb_dat_i[8];
				end
				default: begin
				end
			endcase
		end
	end

	// Read mux; unmapped addresses read zero
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wb_dat_o <= 32'h00000000;
		end else if (wbRead) begin
			case (wb_adr_i)
				`REG_MODE:     wb_dat_o <= {bitDiv_q, deviation_q, 2'h0, ifGain_q, 1'b0, mode_q};
				`REG_RXCFG:    wb_dat_o <= {12'h000, center_q, cutoff_q, passive_q, 3'h0, rxCtrl_q};
				`REG_ALARM:    wb_dat_o <= {23'h000000, alarmMask_q, alarmLevel_q};
				`REG_STRENGTH: wb_dat_o <= {15'h0000, alarmFlag_q, 8'h00, strength};
				default:       wb_dat_o <= 32'h00000000;
			endcase
		end
	end

	// ****************************************
	// Analog control outputs
	// ****************************************
	assign receiveActive          = (mode_q == `MODE_RX_CODE);
	assign ifGainSelect           = ifGain_q;
	assign complexFilterEnable    = rxCtrl_q[`FILT_EN_BIT];
	assign passiveFilterBandwidth = passive_q;
	assign lowpassCutoffSelect    = cutoff_q;
	assign complexFilterCenter    = center_q;

	// ****************************************
	// Strength sampling
	// ****************************************
	// Reference frequency = XTAL/(32*(1+dev)); sample 16x faster, so divide clk
	// by CLK*2*(1+dev)/XTAL. Integer math loses a little accuracy; acceptable
	// since absolute strength accuracy is already a few dB.
	wire [31:0] sampDivFull = ((32'd2 * `CLK_HZ) / `XTAL_HZ) * ({24'h0, deviation_q} + 32'd1);
	wire [15:0] sampDiv     = sampDivFull[15:0];
	wire        sampleTick;

	clk_divider #(.WIDTH(16)) sampler (
		.clk     (clk),
		.nrst    (nrst),
		.run     (receiveActive),
		.divisor (sampDiv),
		.tick    (sampleTick)
	);

	// Sliding average of 16 samples, LSB is 0.5 dB
	window_avg #(.DW(LEVEL_W), .LOG_N(4)) averager (
		.clk      (clk),
		.nrst     (nrst),
		.sampleEn (sampleTick),
		.sampleIn (lvlStable_q),
		.avgOut   (strength),
		.avgValid (strengthValid)
	);

	// ****************************************
	// Alarm flag and routing
	// ****************************************
	wire alarmClr = wbWrite & (wb_adr_i == `REG_STRENGTH) & wb_sel_i[2]
	              & wb_dat_i[16];
	wire alarmSet = strengthValid & (strength > alarmLevel_q);

	// Set wins over a simultaneous write-one clear
	always @(posedge clk or negedge nrst) begin
		if (!nrst)         alarmFlag_q <= 1'b0;
		else if (alarmSet) alarmFlag_q <= 1'b1;
		else if (alarmClr) alarmFlag_q <= 1'b0;
	end

	// One route bit per pin; both pins may carry the alarm at once
	wire [1:0] pinDrive;
	genvar     g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : gPin
			assign pinDrive[g] = alarmFlag_q & rxCtrl_q[`ROUTE0_BIT + g];
		end
	endgenerate

	// Pins are levels, not pulses: they follow the flag until it is cleared
	assign event_pin_0 = pinDrive[0];
	assign event_pin_1 = pinDrive[1];
	assign irq         = alarmFlag_q & alarmMask_q;

	// ****************************************
	// Demodulator and bit synchronizer
	// ****************************************
	// Polarity from which channel leads: I rising while Q high means +90 deg
	reg  iPrev_q;
	reg  demodBit_q;
	wire bitTick;

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			iPrev_q    <= 1'b0;
			demodBit_q <= 1'b0;
		end else begin
			iPrev_q <= iSync_q[1];
			if (iSync_q[1] & ~iPrev_q) demodBit_q <= qSync_q[1];
		end
	end

	clk_divider #(.WIDTH(16)) bitClock (
		.clk     (clk),
		.nrst    (nrst),
		.run     (receiveActive),
		.divisor (bitDiv_q),
		.tick    (bitTick)
	);

	// Bit sync samples once per bit; raw path bypasses it when disabled
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			dataOut      <= 1'b0;
			dataClk      <= 1'b0;
			fifoBitValid <= 1'b0;
			fifoBit      <= 1'b0;
		end else begin
			fifoBitValid <= 1'b0;
			if (!rxCtrl_q[`BITSYNC_EN_BIT]) begin
				dataOut <= demodBit_q;
				dataClk <= 1'b0;
			end else if (bitTick) begin
				if (rxCtrl_q[`BUFFERED_BIT]) begin
					fifoBit      <= demodBit_q;
					fifoBitValid <= 1'b1;
				end else begin
					dataOut <= demodBit_q;
					dataClk <= ~dataClk;
				end
			end
		end
	end
endmodule // rx_signal_strength_monitor

/* rtl/rx_strength_regs.vh */
// Register offsets, field positions, reset values and timing constants for the strength monitor
`ifndef RX_STRENGTH_REGS_VH
`define RX_STRENGTH_REGS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define REG_MODE        4'h0
`define REG_RXCFG       4'h4
`define REG_ALARM       4'h8
`define REG_STRENGTH    4'hC

// ****************************************
// Field positions and codes
// ****************************************
`define MODE_RX_CODE    3'h3
`define MODE_RESET      3'h1
`define IFGAIN_RESET    2'h0
`define DEV_RESET       8'h03
`define FILT_EN_BIT     0
`define ROUTE0_BIT      1
`define ROUTE1_BIT      2
`define BITSYNC_EN_BIT  3
`define BUFFERED_BIT    4
`define STAT_ALARM_BIT  0

// ****************************************
// Timing
// ****************************************
`define CLK_HZ          50000000
`define XTAL_HZ         12800000
`define SAMPLES_PER_PER 16
`define BITRATE_DIV_RST 16'h0040

`endif

/* rtl/window_avg.v */
// Sliding window averager: average of the last N samples, memory kept in registers
`timescale 1ns/1ns
module window_avg #(
	parameter DW    = 8,
	parameter LOG_N = 4
) (
	// Clock and reset
	input  wire          clk,
	input  wire          nrst,
	// Sample in
	input  wire          sampleEn,
	input  wire [DW-1:0] sampleIn,
	// Average out, refreshed on each sample
	output reg  [DW-1:0] avgOut,
	output reg           avgValid
);
	localparam N = 1 << LOG_N;
	reg [DW-1:0]       mem [0:N-1];
	reg [LOG_N-1:0]    wrPtr_q;
	reg [DW+LOG_N-1:0] sum_q;
	wire [DW+LOG_N-1:0] sum_d;
	integer i;

	// Add newest, drop oldest: running window sum
	assign sum_d = sum_q + {{LOG_N{1'b0}}, sampleIn} - {{LOG_N{1'b0}}, mem[wrPtr_q]};

	// Window memory, pointer, and registered average
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			for (i = 0; i < N; i = i + 1) mem[i] <= {DW{1'b0}};
			wrPtr_q  <= {LOG_N{1'b0}};
			sum_q    <= {(DW+LOG_N){1'b0}};
			avgOut   <= {DW{1'b0}};
			avgValid <= 1'b0;
		end else begin
			avgValid <= sampleEn;
			if (sampleEn) begin
				mem[wrPtr_q] <= sampleIn;
				wrPtr_q      <= wrPtr_q + {{(LOG_N-1){1'b0}}, 1'b1};
				sum_q        <= sum_d;
				avgOut       <= sum_d[DW+LOG_N-1:LOG_N];
			end
		end
	end
endmodule // window_avg

/* tb/front_end_model.sv */
// Stand-in for the analog front end: quadrature comparator bits and a level word
`timescale 1ns/1ns
module front_end_model (
	// Clock
	input  wire       clk,
	// Bench stimulus
	input  wire       lead,
	input  wire [7:0] level,
	// Towards the block
	output reg        basebandI,
	output reg        basebandQ,
	output wire [7:0] rawLevel
);
	reg [3:0] phase = 4'h0;

	// Level is held by the bench; the block syncs it
	assign rawLevel = level;

	// Sixteen-cycle quadrature pair; Q sits at the lead value around every I rise
	always @(posedge clk) begin
		phase     <= phase + 4'h1;
		basebandI <= phase[3];
		basebandQ <= phase[3] ^ phase[2] ^ ~lead;
	end
endmodule // front_end_model

/* tb/rx_strength_properties.sv */
// Port-level checks for the strength monitor
`timescale 1ns/1ns
`include "rx_strength_regs.vh"
module rx_strength_properties (
	// Clock and reset
	input wire        clk,
	input wire        nrst,
	// Bus
	input wire        wb_cyc_i,
	input wire        wb_stb_i,
	input wire        wb_we_i,
	input wire [3:0]  wb_adr_i,
	input wire [3:0]  wb_sel_i,
	input wire [31:0] wb_dat_i,
	input wire [31:0] wb_dat_o,
	input wire        wb_ack_o,
	// Watched outputs
	input wire        receiveActive,
	input wire [1:0]  ifGainSelect,
	input wire        complexFilterEnable,
	input wire        fifoBitValid,
	input wire        event_pin_0
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	// Low-lane write seen at its ack edge, and the fields it carries
	wire       req    = wb_cyc_i && wb_stb_i;
	wire       wrLo   = req && wb_we_i && wb_ack_o && wb_sel_i[0];
	wire [2:0] modeIn = wb_dat_i[2:0];
	wire [1:0] gainIn = wb_dat_i[5:4];
	wire       filtIn = wb_dat_i[0];

	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than a cycle");
	a_ack_answer: assert property (req && !wb_ack_o |=> wb_ack_o)
		else $error("request unanswered");
	a_mode_rx: assert property (wrLo && wb_adr_i == `REG_MODE |=>
		receiveActive == ($past(modeIn) == `MODE_RX_CODE)) else $error("receive flag wrong");
	a_gain_field: assert property (wrLo && wb_adr_i == `REG_MODE |=>
		ifGainSelect == $past(gainIn)) else $error("gain select wrong");
	a_filter_bit: assert property (wrLo && wb_adr_i == `REG_RXCFG |=>
		complexFilterEnable == $past(filtIn)) else $error("filter enable wrong");
	a_pin_sticky: assert property (event_pin_0 && !(req && wb_we_i) |=> event_pin_0)
		else $error("event pin dropped without a write");
	a_rdata_hold: assert property (!(req && !wb_we_i) |=> $stable(wb_dat_o))
		else $error("read data moved without a read");
	a_fifo_pulse: assert property (fifoBitValid |=> !fifoBitValid)
		else $error("bit strobe too long");

	cover property (wrLo && wb_adr_i == `REG_MODE);
	cover property ($rose(event_pin_0));
	cover property (fifoBitValid);
endmodule // rx_strength_properties

/* tb/tb.sv */
// Self-checking bench for the strength monitor
`timescale 1ns/1ns
`include "rx_strength_regs.vh"
module tb;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic        wb_cyc_i = 1'b0;
	logic        wb_stb_i = 1'b0;
	logic        wb_we_i = 1'b0;
	logic [3:0]  wb_adr_i = 4'h0;
	logic [3:0]  wb_sel_i = 4'hF;
	logic [31:0] wb_dat_i = 32'h0;
	logic        lead = 1'b0;
	logic [7:0]  level = 8'h00;
	logic [31:0] r;
	wire  [31:0] wb_dat_o;
	wire  [7:0]  rawLevel;
	wire  [1:0]  ifGainSelect;
	wire         wb_ack_o, basebandI, basebandQ, receiveActive, complexFilterEnable;
	wire         dataOut, fifoBitValid, event_pin_0, event_pin_1, irq;
	wire         dataClk, fifoBit;
	wire  [3:0]  passiveFilterBandwidth, lowpassCutoffSelect, complexFilterCenter;
	int          n_fail = 0;
	int          n_tests = 0;

	always #10 clk = ~clk;

	front_end_model u_fe (.clk, .lead, .level, .basebandI, .basebandQ, .rawLevel);
	rx_signal_strength_monitor u_dut (.clk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
		.wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .basebandI, .basebandQ, .rawLevel,
		.receiveActive, .ifGainSelect, .complexFilterEnable, .passiveFilterBandwidth,
		.lowpassCutoffSelect, .complexFilterCenter, .dataOut, .dataClk, .fifoBitValid,
		.fifoBit, .event_pin_0, .event_pin_1, .irq);

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			n_fail++;
			$display("Error %0t: saw %h want %h", $time, s, e);
		end
	endtask

	// Classic cycle: hold until ack is sampled, release at that edge
	task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		n = 0;
		@(posedge clk);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, we, a, d, s};
		do begin
			@(posedge clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		if (n >= 20) chk(32'h0, 32'h1);
		r = wb_dat_o;
		{wb_cyc_i, wb_stb_i} <= 2'b00;
		@(negedge clk);
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 4'hF);
	endtask

	// Waits long enough for the 16-sample window to refill at deviation 3
	task automatic soak;
		repeat (700) @(negedge clk);
	endtask

	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_config;
		chk(32'(ifGainSelect), 32'h0);
		bus(1'b0, `REG_MODE, 32'h0, 4'hF);
		chk(r, 32'h0040_0301);
		for (int c = 0; c < 8; c++) begin
			wr(`REG_MODE, {16'h0040, 8'h03, 2'b00, 2'(c), 1'b0, 3'(c)});
			chk(32'(receiveActive), 32'(c == 3));
			chk(32'(ifGainSelect), 32'(c % 4));
		end
		wr(`REG_MODE, 32'h0040_0301);
		wr(`REG_RXCFG, 32'h1);
		bus(1'b1, `REG_RXCFG, 32'h0, 4'hE);
		chk(32'(complexFilterEnable), 32'h1);
		wr(`REG_RXCFG, 32'h0003_5401);
		chk(32'({complexFilterCenter, lowpassCutoffSelect, passiveFilterBandwidth}), 32'h354);
		wr(`REG_RXCFG, 32'h0);
		chk(32'(complexFilterEnable), 32'h0);
		bus(1'b0, 4'h1, 32'h0, 4'hF);
		chk(r, 32'h0);
		$display("config done");
	endtask

	task automatic t_alarm;
		level <= 8'h28;
		wr(`REG_RXCFG, 32'h0003_0003);
		wr(`REG_ALARM, 32'h128);
		wr(`REG_MODE, 32'h0040_0303);
		soak;
		bus(1'b0, `REG_STRENGTH, 32'h0, 4'hF);
		chk(r, 32'h28);
		level <= 8'h29;
		soak;
		bus(1'b0, `REG_STRENGTH, 32'h0, 4'hF);
		chk(r, 32'h0001_0029);
		chk(32'({event_pin_0, event_pin_1, irq}), 32'h5);
		level <= 8'h28;
		soak;
		chk(32'({event_pin_0, event_pin_1, irq}), 32'h5);
		wr(`REG_STRENGTH, 32'h0001_0000);
		chk(32'({event_pin_0, event_pin_1, irq}), 32'h0);
		wr(`REG_RXCFG, 32'h4);
		wr(`REG_ALARM, 32'h28);
		level <= 8'h29;
		soak;
		wr(`REG_STRENGTH, 32'h0);
		chk(32'({event_pin_0, event_pin_1, irq}), 32'h2);
		$display("alarm done");
	endtask

	task automatic t_data;
		int cnt;
		logic dcPrev;
		cnt = 0;
		wr(`REG_RXCFG, 32'h0);
		wr(`REG_MODE, 32'h0040_0703);
		for (int p = 0; p < 2; p++) begin
			@(posedge clk);
			lead <= p[0];
			repeat (64) @(negedge clk);
			chk(32'(dataOut), 32'(p));
		end
		wr(`REG_RXCFG, 32'h18);
		repeat (320) @(negedge clk) cnt += (fifoBitValid === 1'b1);
		chk(32'(cnt > 3), 32'h1);
		chk(32'(fifoBit), 32'h1);
		wr(`REG_RXCFG, 32'h08);
		cnt = 0;
		dcPrev = dataClk;
		repeat (320) begin
			@(negedge clk);
			cnt += (dataClk !== dcPrev);
			dcPrev = dataClk;
		end
		chk(32'(cnt > 3), 32'h1);
		chk(32'(dataOut), 32'h1);
		$display("data done");
	endtask

	// Main sequence; reset held for two edges
	initial begin
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		t_config;
		t_alarm;
		t_data;
		finish_test;
	end

	// Watchdog sized well above the scenarios' length
	initial begin
		#(20 * 20000);
		n_fail++;
		finish_test;
	end
endmodule // tb

bind rx_signal_strength_monitor rx_strength_properties u_props (.clk, .nrst, .wb_cyc_i,
	.wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
	.receiveActive, .ifGainSelect, .complexFilterEnable, .fifoBitValid, .event_pin_0);
